// ### rtl/lrip_consts.svh
// offsets, field positions and reset values for the relay and input port
`ifndef LRIP_CONSTS_SVH
`define LRIP_CONSTS_SVH
`define LRIP_ADDR_W 4
`define LRIP_OFF_RELAY_LO 4'h0
`define LRIP_OFF_RELAY_HI 4'h2
`define LRIP_OFF_INPUTS 4'h4
`define LRIP_OFF_COS 4'h6
`define LRIP_OFF_IRQ 4'h8
`define LRIP_BIT_ACK_COS 0
`define LRIP_BIT_ACK_CH0 1
`define LRIP_BIT_ACK_CH1 2
`define LRIP_BIT_EN_COS 8
`define LRIP_BIT_EN_CH0 9
`define LRIP_BIT_EN_CH1 10
`define LRIP_RST_WORD 16'h0000
`define LRIP_RST_EN 3'h0
`define LRIP_SYNC_STAGES 3
`endif

// ### rtl/lrip_pkg.sv
// types shared by the relay and input port modules
package lrip_pkg;
	typedef logic [15:0] lrip_word_t;
	typedef enum logic [1:0] {
		LRIP_MODE_OFF,
		LRIP_MODE_COS,
		LRIP_MODE_EDGE
	} lrip_mode_e;
endpackage

// ### rtl/lrip_sync_if.sv
// carrier between the port top and its input synchroniser
`timescale 1ns/1ps
interface lrip_sync_if;
	logic [15:0] level;
	logic [15:0] rise;
	logic [15:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// ### rtl/lrip_in_sync.sv
// three-stage input synchroniser with agreement check and edge detect
`timescale 1ns/1ps
`include "lrip_consts.svh"
module lrip_in_sync
	import lrip_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] pins_i,
	lrip_sync_if.src sync
);
	logic [15:0] s1_r;
	logic [15:0] s2_r;
	logic [15:0] s3_r;
	logic [15:0] level_r;
	logic [15:0] agree;
	assign agree = ~(s2_r ^ s3_r);
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r <= `LRIP_RST_WORD;
			s2_r <= `LRIP_RST_WORD;
			s3_r <= `LRIP_RST_WORD;
		end else begin
			s1_r <= pins_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// level follows a channel only when stages two and three agree
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_r <= `LRIP_RST_WORD;
		end else begin
			level_r <= (s3_r & agree) | (level_r & ~agree);
		end
	end
	// one event per transition: compare new level against held one
	assign sync.level = level_r;
	assign sync.rise = s3_r & agree & ~level_r;
	assign sync.fall = ~s3_r & agree & level_r;
	AST_ONE_EVENT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(sync.rise | sync.fall) != 16'h0000
		|=> ((sync.rise | sync.fall) & $past(sync.rise | sync.fall)) == 16'h0000)
		else $error("edge event repeated on consecutive cycles");
endmodule

// ### rtl/lrip_port.sv
// relay output, isolated input and interrupt register block
`timescale 1ns/1ps
`include "lrip_consts.svh"
// What this block does
// - board id bit is inverted switch; switch 1 is lsb, all on gives 0
// - all registers are 16 bits, reached by 16-bit accesses at offsets
// - decode 0x00/0x02 relays, 0x04 inputs, 0x06 state change, 0x08 irq
// - pair (0,1) drives the relay into its reset state
// - pair (1,0) drives the relay into its set state
// - local relay k uses bit 2k reset and bit 2k+1 set
// - readback bit x is 1 when relay x is set
// - input register returns present level of all sixteen inputs
// - per-channel enable; any edge on enabled channel is an event
// - event captures inputs when bit 8 alone is set, held until ack, then capture clears
// - bit 8 enables the state change interrupt source
// - bits 9 and 10 enable rising edge interrupts of inputs 0 and 1
// - both edge enables without bit 8 fire on either rising edge
// - both modes share one interrupt line
// - state change enable together with an edge enable means disabled
// - a raised request stays pending until the host clears it
// - writing 1 to bits 0..2 clears the matching pending request
// - irq read shows pending in bits 0..2 and enables in bits 8..10
module lrip_port
	import lrip_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [`LRIP_ADDR_W-1:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_wdata_i,
	output logic [15:0] io_rdata_o,
	input wire logic [15:0] iso_in_i,
	input wire logic [3:0] board_id_switch_on_i,
	output logic [3:0] board_id_o,
	output logic [15:0] relay_set_command_o,
	output logic [15:0] relay_reset_command_o,
	output logic [15:0] relay_state_o,
	output logic irq_o
);
	logic rst_m_r;
	logic rst_n;
	lrip_sync_if sync_bus ();
	lrip_word_t relay_state_r;
	lrip_word_t set_cmd_r;
	lrip_word_t rst_cmd_r;
	lrip_word_t cos_on_r;
	lrip_word_t capture_r;
	lrip_word_t rdata_r;
	logic [3:0] sw_m_r;
	logic [3:0] sw_a_r;
	logic [3:0] sw_b_r;
	logic [3:0] board_id_r;
	logic [2:0] irq_on_r;
	logic [2:0] pend_r;
	logic [2:0] ack;
	logic [2:0] hit;
	logic cos_event;
	logic wr_relay_lo;
	logic wr_relay_hi;
	logic wr_cos;
	logic wr_irq;
	lrip_mode_e mode;
	default clocking core_cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n);

	// reset release through two flops
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_m_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n <= rst_m_r;
		end
	end

	lrip_in_sync u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.pins_i(iso_in_i),
		.sync(sync_bus)
	);

	function automatic logic hit_off(input logic [`LRIP_ADDR_W-1:0] a,
		input logic [`LRIP_ADDR_W-1:0] off);
		hit_off = (a == off);
	endfunction

	// writes decoded as whole 16-bit words only
	assign wr_relay_lo = io_wr_i && hit_off(io_addr_i, `LRIP_OFF_RELAY_LO);
	assign wr_relay_hi = io_wr_i && hit_off(io_addr_i, `LRIP_OFF_RELAY_HI);
	assign wr_cos = io_wr_i && hit_off(io_addr_i, `LRIP_OFF_COS);
	assign wr_irq = io_wr_i && hit_off(io_addr_i, `LRIP_OFF_IRQ);

	// relay pairs: even bit resets, odd bit sets, eight relays per word
	genvar k;
	generate
		for (k = 0; k < 8; k++) begin : g_pair
			always_ff @(posedge core_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					rst_cmd_r[k] <= 1'b0;
					set_cmd_r[k] <= 1'b0;
					rst_cmd_r[k+8] <= 1'b0;
					set_cmd_r[k+8] <= 1'b0;
				end else begin
					if (wr_relay_lo) begin
						rst_cmd_r[k] <= io_wdata_i[2*k];
						set_cmd_r[k] <= io_wdata_i[2*k+1];
					end
					if (wr_relay_hi) begin
						rst_cmd_r[k+8] <= io_wdata_i[2*k];
						set_cmd_r[k+8] <= io_wdata_i[2*k+1];
					end
				end
			end
		end
	endgenerate

	// latched state follows the last valid pair; (1,1) leaves it alone
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			relay_state_r <= `LRIP_RST_WORD;
		end else begin
			relay_state_r <= (relay_state_r | (set_cmd_r & ~rst_cmd_r))
				& ~(rst_cmd_r & ~set_cmd_r);
		end
	end

	assign relay_set_command_o = set_cmd_r;
	assign relay_reset_command_o = rst_cmd_r;
	assign relay_state_o = relay_state_r;

	// board id: closed switch reads as 0, switch 1 is bit 0
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sw_m_r <= 4'h0;
			sw_a_r <= 4'h0;
			sw_b_r <= 4'h0;
			board_id_r <= 4'h0;
		end else begin
			sw_m_r <= board_id_switch_on_i;
			sw_a_r <= sw_m_r;
			sw_b_r <= sw_a_r;
			if (sw_a_r == sw_b_r) begin
				board_id_r <= ~sw_b_r;
			end
		end
	end
	assign board_id_o = board_id_r;

	// state change channel enables
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cos_on_r <= `LRIP_RST_WORD;
		end else if (wr_cos) begin
			cos_on_r <= io_wdata_i;
		end
	end

	// interrupt source enables
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_on_r <= `LRIP_RST_EN;
		end else if (wr_irq) begin
			irq_on_r <= {io_wdata_i[`LRIP_BIT_EN_CH1], io_wdata_i[`LRIP_BIT_EN_CH0],
				io_wdata_i[`LRIP_BIT_EN_COS]};
		end
	end

	// mode from the enable combination; forbidden mixes are disabled
	always_comb begin
		case (irq_on_r)
			3'b001: mode = LRIP_MODE_COS;
			3'b010, 3'b100, 3'b110: mode = LRIP_MODE_EDGE;
			default: mode = LRIP_MODE_OFF;
		endcase
	end

	assign cos_event = ((sync_bus.rise | sync_bus.fall) & cos_on_r) != 16'h0000;
	assign hit[0] = (mode == LRIP_MODE_COS) && cos_event;
	assign hit[1] = (mode == LRIP_MODE_EDGE) && irq_on_r[1] && sync_bus.rise[0];
	assign hit[2] = (mode == LRIP_MODE_EDGE) && irq_on_r[2] && sync_bus.rise[1];
	assign ack = wr_irq ? {io_wdata_i[`LRIP_BIT_ACK_CH1], io_wdata_i[`LRIP_BIT_ACK_CH0],
		io_wdata_i[`LRIP_BIT_ACK_COS]} : 3'h0;

	// pending requests stay until acknowledged; a new event wins over ack
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 3'h0;
		end else begin
			pend_r <= hit | (pend_r & ~ack);
		end
	end

	// capture the level a first event settles to, cleared by acknowledge
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			capture_r <= `LRIP_RST_WORD;
		end else if (hit[0] && (!pend_r[0] || ack[0])) begin
			capture_r <= sync_bus.level ^ (sync_bus.rise | sync_bus.fall);
		end else if (ack[0]) begin
			capture_r <= `LRIP_RST_WORD;
		end
	end

	assign irq_o = |pend_r;

	// read data registered one cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= `LRIP_RST_WORD;
		end else if (io_rd_i) begin
			case (io_addr_i)
				`LRIP_OFF_RELAY_HI: rdata_r <= relay_state_r;
				`LRIP_OFF_INPUTS: rdata_r <= sync_bus.level;
				`LRIP_OFF_COS: rdata_r <= capture_r;
				`LRIP_OFF_IRQ: rdata_r <= {5'h00, irq_on_r, 5'h00, pend_r};
				default: rdata_r <= `LRIP_RST_WORD;
			endcase
		end
	end
	assign io_rdata_o = rdata_r;

	AST_RELAY_SET: assert property (
		wr_relay_lo && io_wdata_i[1:0] == 2'b10 ##1 !wr_relay_lo |=> relay_state_r[0])
		else $error("relay 0 not set after set pair");
	AST_RELAY_RESET: assert property (
		wr_relay_hi && io_wdata_i[3:2] == 2'b01 ##1 !wr_relay_hi |=> !relay_state_r[9])
		else $error("relay 9 not reset after reset pair");
	AST_READBACK: assert property (
		io_rd_i && io_addr_i == `LRIP_OFF_RELAY_HI |=> io_rdata_o == $past(relay_state_r))
		else $error("readback mismatch");
	AST_INPUT_READ: assert property (
		io_rd_i && io_addr_i == `LRIP_OFF_INPUTS |=> io_rdata_o == $past(sync_bus.level))
		else $error("input read mismatch");
	AST_FORBIDDEN: assert property (
		irq_on_r[0] && irq_on_r[2:1] != 2'b00 |-> hit == 3'h0)
		else $error("forbidden mix raised a request");
	AST_PENDING_HOLDS: assert property (
		pend_r[1] && !ack[1] |=> pend_r[1])
		else $error("channel 0 request dropped without ack");
	AST_ACK_CLEARS: assert property (
		ack[0] && !hit[0] |=> !pend_r[0] && capture_r == 16'h0000)
		else $error("ack did not clear request and capture");
	AST_CH0_RISE: assert property (
		irq_on_r == 3'b010 && sync_bus.rise[0] |=> pend_r[1] && irq_o)
		else $error("channel 0 rising edge missed");
	AST_COS_FIRE: assert property (
		irq_on_r == 3'b001 && cos_event && !pend_r[0]
		|=> pend_r[0] && capture_r == sync_bus.level)
		else $error("state change not captured");
	AST_CH1_EITHER: assert property (
		irq_on_r == 3'b110 && sync_bus.rise[1] |=> pend_r[2])
		else $error("channel 1 edge missed in dual mode");
	AST_BOARD_ID: assert property (
		sw_a_r == sw_b_r |=> board_id_o == ~$past(sw_b_r))
		else $error("board id not inverted switch");
	AST_COS_QUIET: assert property (
		((sync_bus.rise | sync_bus.fall) & cos_on_r) == 16'h0000 && !pend_r[0] |=> !pend_r[0])
		else $error("state change request without enabled edge");
	AST_CH0_NO_FALL: assert property (
		!sync_bus.rise[0] && !pend_r[1] |=> !pend_r[1])
		else $error("channel 0 request without rising edge");
	AST_CH1_ONLY: assert property (
		irq_on_r == 3'b100 && sync_bus.rise[1] |=> pend_r[2])
		else $error("channel 1 rising edge missed");
	AST_ACK_CH0: assert property (
		ack[1] && !hit[1] |=> !pend_r[1])
		else $error("ack did not clear channel 0 request");
	AST_ACK_ZERO_NOP: assert property (
		wr_irq && !io_wdata_i[`LRIP_BIT_ACK_COS] && pend_r[0] |=> pend_r[0])
		else $error("zero ack bit cleared a request");
	AST_IRQ_LINE: assert property (
		hit != 3'h0 |=> irq_o)
		else $error("shared line not raised by a request");
	AST_CAPTURE_HOLD: assert property (
		pend_r[0] && !ack[0] |=> $stable(capture_r))
		else $error("capture changed while request pending");
	AST_CMD_HOLD: assert property (
		!wr_relay_lo && !wr_relay_hi
		|=> $stable(relay_set_command_o) && $stable(relay_reset_command_o))
		else $error("relay command changed without a write");
	AST_RDATA_HOLD: assert property (
		!io_rd_i |=> $stable(io_rdata_o))
		else $error("read data changed without a read");
	AST_COS_ON_WRITE: assert property (
		wr_cos |=> cos_on_r == $past(io_wdata_i))
		else $error("channel enables not taken from write");
	AST_UNMAPPED: assert property (
		io_rd_i && io_addr_i == `LRIP_OFF_RELAY_LO |=> io_rdata_o == 16'h0000)
		else $error("write-only offset read not zero");
	AST_IRQ_READ: assert property (
		io_rd_i && io_addr_i == `LRIP_OFF_IRQ
		|=> io_rdata_o[10:8] == $past(irq_on_r) && io_rdata_o[2:0] == $past(pend_r))
		else $error("interrupt status read mismatch");
	COV_COS: cover property (hit[0]);
	COV_DUAL: cover property (irq_on_r == 3'b110 && hit[2]);
	COV_ACK: cover property (pend_r[0] && ack[0]);
	COV_RELAY: cover property ($rose(relay_state_r[15]));
	COV_CH1_ONLY: cover property (irq_on_r == 3'b100 && hit[2]);
endmodule

// ### bench/lrip_host.sv
// host model issuing 16-bit register reads and writes
`timescale 1ns/1ps
module lrip_host (
	input wire logic core_clk_i,
	input wire logic [15:0] io_rdata_i,
	output logic [3:0] io_addr_o,
	output logic io_wr_o,
	output logic io_rd_o,
	output logic [15:0] io_wdata_o
);
	initial begin
		io_addr_o = 4'hf;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = 16'h0000;
	end
	// one whole word per write, strobe high for one cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		io_addr_o <= a;
		io_wdata_o <= d;
		io_wr_o <= 1'b1;
		@(posedge core_clk_i);
		io_wr_o <= 1'b0;
		io_addr_o <= ~a;
		io_wdata_o <= ~d;
	endtask
	// read data is taken one cycle after the read edge
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk_i);
		io_addr_o <= a;
		io_rd_o <= 1'b1;
		@(posedge core_clk_i);
		io_rd_o <= 1'b0;
		io_addr_o <= ~a;
		@(posedge core_clk_i);
		d = io_rdata_i;
	endtask
endmodule

// ### bench/lrip_port_bench.sv
// self-checking bench for the relay and input port
`timescale 1ns/1ps
module lrip_port_bench;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] io_addr;
	logic io_wr;
	logic io_rd;
	logic [15:0] io_wdata;
	logic [15:0] io_rdata;
	logic [15:0] iso_in = 16'h0000;
	logic [3:0] sw_on = 4'h0;
	logic [3:0] board_id;
	logic [15:0] relay_set;
	logic [15:0] relay_rst;
	logic [15:0] relay_state;
	logic irq;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	logic [3:0] swv [4] = '{4'h0, 4'h1, 4'hf, 4'h6};

	always #2 core_clk = ~core_clk;

	lrip_port u_lrip_port (.core_clk_i(core_clk), .arst_n_i(arst_n), .io_addr_i(io_addr),
		.io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
		.iso_in_i(iso_in), .board_id_switch_on_i(sw_on), .board_id_o(board_id),
		.relay_set_command_o(relay_set), .relay_reset_command_o(relay_rst),
		.relay_state_o(relay_state), .irq_o(irq));

	lrip_host u_lrip_host (.core_clk_i(core_clk), .io_rdata_i(io_rdata), .io_addr_o(io_addr),
		.io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] v;
		u_lrip_host.rd(a, v);
		chk(v, exp);
	endtask

	task automatic pins(input logic [15:0] v);
		@(posedge core_clk);
		iso_in <= v;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(relay_set, 16'h0000);
		chk(relay_rst, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		rdc(4'h8, 16'h0000);
		rdc(4'h6, 16'h0000);
		rdc(4'h2, 16'h0000);
		rdc(4'ha, 16'h0000);
		// board id is the inverse of the switches, switch 1 in bit 0
		foreach (swv[i]) begin
			@(posedge core_clk);
			sw_on <= swv[i];
			repeat (8) @(posedge core_clk);
			chk({12'h0, board_id}, {12'h0, ~swv[i]});
		end
		// relay pairs, never (1,1)
		u_lrip_host.wr(4'h0, 16'haaaa);
		rdc(4'h2, 16'h00ff);
		u_lrip_host.wr(4'h2, 16'h9006);
		@(posedge core_clk);
		chk(relay_rst, 16'h4200);
		chk(relay_set, 16'h81ff);
		rdc(4'h2, 16'h81ff);
		u_lrip_host.wr(4'h0, 16'h5555);
		rdc(4'h2, 16'h8100);
		chk(relay_state, 16'h8100);
		chk(relay_set, 16'h8100);
		chk(relay_rst, 16'h42ff);
		rdc(4'h0, 16'h0000);
		pins(16'h1234);
		rdc(4'h4, 16'h1234);
		// state change on channel 4 only
		u_lrip_host.wr(4'h6, 16'h0010);
		u_lrip_host.wr(4'h8, 16'h0100);
		pins(16'h123c);
		rdc(4'h8, 16'h0100);
		pins(16'h122c);
		rdc(4'h8, 16'h0101);
		chk({15'h0, irq}, 16'h0001);
		rdc(4'h6, 16'h122c);
		pins(16'h123c);
		u_lrip_host.wr(4'h8, 16'h0100);
		rdc(4'h8, 16'h0101);
		rdc(4'h6, 16'h122c);
		u_lrip_host.wr(4'h8, 16'h0101);
		rdc(4'h8, 16'h0100);
		rdc(4'h6, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		// rising edges of inputs 0 and 1
		u_lrip_host.wr(4'h8, 16'h0600);
		pins(16'h123d);
		rdc(4'h8, 16'h0602);
		pins(16'h123f);
		rdc(4'h8, 16'h0606);
		chk({15'h0, irq}, 16'h0001);
		u_lrip_host.wr(4'h8, 16'h0602);
		rdc(4'h8, 16'h0604);
		u_lrip_host.wr(4'h8, 16'h0604);
		pins(16'h123c);
		rdc(4'h8, 16'h0600);
		// forbidden enable mix behaves as disabled
		u_lrip_host.wr(4'h8, 16'h0300);
		pins(16'h122d);
		rdc(4'h8, 16'h0300);
		chk({15'h0, irq}, 16'h0000);
		// input 1 alone: its rise counts, a rise of input 0 does not
		u_lrip_host.wr(4'h8, 16'h0400);
		pins(16'h122e);
		rdc(4'h8, 16'h0404);
		pins(16'h122f);
		rdc(4'h8, 16'h0404);
		chk({15'h0, irq}, 16'h0001);
		u_lrip_host.wr(4'h8, 16'h0404);
		rdc(4'h8, 16'h0400);
		chk({15'h0, irq}, 16'h0000);
		conclude();
	end
endmodule
